/* File: logic/operation_mode_supply_control.sv */
// Operation-mode controller with supply-level gating.
`timescale 1ns/10ps
`default_nettype none
module operation_mode_supply_control
   import opmode_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic sleep_ctrl_pin,
   input wire logic [1:0] direct_input_pins,
   input wire logic [3:0] channel_on_bits,
   input wire logic hold_active_bit,
   input wire logic logic_supply_uv,
   input wire logic logic_supply_low_op,
   input wire logic battery_supply_low,
   input wire logic battery_above_op,
   output logic [1:0] mode,
   output logic [3:0] channel_drive,
   output logic regs_reset,
   output logic serial_write_en,
   output logic serial_read_en,
   output logic serial_out_tristate,
   output logic serial_slow_only
);
   mode_t mode_r, mode_nxt;
   logic [1:0] sync1_r, sync2_r;
   logic sl1_r, sl2_r;
   logic [3:0] wait_r, wait_nxt;
   logic [3:0] drive_r, drive_nxt;
   logic [3:0] lk0_r, lk1_r, lka_r, lkb_r, lk2_r, lk2_nxt;
   logic [3:0] lk_flags;
   logic any_in, req, limp_ok, hold;

   // Pins from outside pass two flops before any decision.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         sl1_r <= 1'b0;
         sl2_r <= 1'b0;
      end
      else
      begin
         sync1_r <= direct_input_pins;
         sync2_r <= sync1_r;
         sl1_r <= sleep_ctrl_pin;
         sl2_r <= sl1_r;
      end
   end

   // Supply comparator levels are captured on the link clock first.
   assign lk_flags = {battery_above_op, battery_supply_low,
                      logic_supply_low_op, logic_supply_uv};
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
         lk0_r <= 4'h1;
      else
         lk0_r <= lk_flags;
   end

   // Each bit then passes two flops on clk, and a new word is taken only
   // once two samples agree, so a bit that settled a cycle late never pairs
   // with stale neighbours. The price is two more cycles of latency.
   assign lk2_nxt = (lka_r == lkb_r) ? lka_r : lk2_r;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lk1_r <= 4'h1;
         lka_r <= 4'h1;
         lkb_r <= 4'h1;
         lk2_r <= 4'h1;
      end
      else
      begin
         lk1_r <= lk0_r;
         lka_r <= lk1_r;
         lkb_r <= lka_r;
         lk2_r <= lk2_nxt;
      end
   end

   function automatic logic [3:0] in_map(input logic [1:0] pins);
      in_map = (pins[0] ? IN0_DEFAULT_CH : CH_ALL_OFF) |
               (pins[1] ? IN1_DEFAULT_CH : CH_ALL_OFF);
   endfunction

   always_comb
   begin
      any_in = |sync2_r;
      // Serial-set bits count only while the logic supply is good.
      req = any_in || (!lk2_r[0] && |channel_on_bits);
      limp_ok = !(lk2_r[0] && lk2_r[2]);
      // The hold bit is a register, so it is void under logic undervoltage.
      hold = hold_active_bit && !lk2_r[0];
      mode_nxt = mode_r;
      wait_nxt = (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
      drive_nxt = drive_r;
      // Decision uses the sleep pin, inputs, channel bits, hold bit and the logic undervoltage and battery-low flags.
      unique case (mode_r)
         MODE_SLEEP, MODE_IDLE:
         begin
            if (!sl2_r && any_in && limp_ok)
               mode_nxt = MODE_LIMP;
            else if (!sl2_r)
               mode_nxt = MODE_SLEEP;
            else if (req)
               mode_nxt = MODE_ACTIVE;
            else
               mode_nxt = MODE_IDLE;
            if (mode_nxt == MODE_ACTIVE || mode_nxt == MODE_LIMP)
               wait_nxt = TRANSITION_CNT;
         end
         MODE_ACTIVE:
         begin
            if (!sl2_r)
               mode_nxt = any_in && limp_ok ? MODE_LIMP : MODE_SLEEP;
            else if (!req && !hold)
               mode_nxt = MODE_IDLE;
         end
         MODE_LIMP:
         begin
            if (!sl2_r && !any_in)
               mode_nxt = MODE_SLEEP;
            else if (!sl2_r && !limp_ok)
               mode_nxt = MODE_SLEEP;
            else if (sl2_r)
               mode_nxt = req ? MODE_ACTIVE : MODE_IDLE;
         end
      endcase
      // Only active and limp-home drive loads, after the transition wait.
      if (wait_nxt != 4'h0 || (lk2_r[0] && lk2_r[2]))
         drive_nxt = CH_ALL_OFF;
      else if (mode_nxt == MODE_ACTIVE)
         drive_nxt = in_map(sync2_r) |
                     (lk2_r[0] ? CH_ALL_OFF : channel_on_bits);
      else if (mode_nxt == MODE_LIMP)
         drive_nxt = in_map(sync2_r);
      else
         drive_nxt = CH_ALL_OFF;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode_r <= MODE_SLEEP;
         wait_r <= 4'h0;
         drive_r <= CH_ALL_OFF;
      end
      else
      begin
         mode_r <= mode_nxt;
         wait_r <= wait_nxt;
         drive_r <= drive_nxt;
      end
   end

   assign mode = mode_r;
   assign channel_drive = drive_r;
   // Register reset in sleep or on logic undervoltage; writes only in idle
   // or active, since limp-home keeps registers read-only.
   assign regs_reset = (mode_r == MODE_SLEEP) || lk2_r[0];
   assign serial_read_en = !regs_reset && mode_r != MODE_SLEEP;
   assign serial_write_en = serial_read_en && mode_r != MODE_LIMP;
   assign serial_out_tristate = !serial_read_en;
   // The host must honour this slower limit; it is advisory here.
   assign serial_slow_only = lk2_r[1] && !lk2_r[3];

   // A wake-up is a cycle in a resting mode followed by a driving mode.
   sequence rest_mode_s;
      mode_r inside {MODE_SLEEP, MODE_IDLE};
   endsequence
   sequence drive_mode_s;
      mode_r inside {MODE_ACTIVE, MODE_LIMP};
   endsequence

   sleep_drive_a: assert property (@(posedge clk) disable iff (rst)
      (mode_r == MODE_SLEEP) |-> channel_drive == CH_ALL_OFF)
      else $error("Channel driven in sleep.");
   sleep_entry_a: assert property (@(posedge clk) disable iff (rst)
      (!sl2_r && !any_in) |=> mode_r == MODE_SLEEP)
      else $error("Sleep not entered.");
   limp_entry_a: assert property (@(posedge clk) disable iff (rst)
      (!sl2_r && any_in && limp_ok) |=> mode_r == MODE_LIMP)
      else $error("Limp-home not entered.");
   active_entry_a: assert property (@(posedge clk) disable iff (rst)
      (sl2_r && req) |=> mode_r == MODE_ACTIVE)
      else $error("Active not entered.");
   idle_return_a: assert property (@(posedge clk) disable iff (rst)
      (sl2_r && !req && !hold_active_bit) |=> mode_r == MODE_IDLE)
      else $error("Idle not resumed.");
   limp_readonly_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == MODE_LIMP |-> !serial_write_en)
      else $error("Write allowed in limp-home.");
   uv_reset_a: assert property (@(posedge clk) disable iff (rst)
      lk2_r[0] |-> regs_reset && !serial_write_en)
      else $error("Registers live under undervoltage.");
   uv_idle_a: assert property (@(posedge clk) disable iff (rst)
      (sl2_r && !any_in && lk2_r[0]) |=> mode_r == MODE_IDLE)
      else $error("Undervoltage did not force idle.");
   turnon_delay_a: assert property (@(posedge clk) disable iff (rst)
      (rest_mode_s ##1 drive_mode_s) |-> channel_drive == CH_ALL_OFF)
      else $error("Turn-on not delayed.");
   turnon_span_a: assert property (@(posedge clk) disable iff (rst)
      (rest_mode_s ##1 drive_mode_s) |-> wait_r == TRANSITION_CNT)
      else $error("Transition wait not loaded.");
   wait_hold_a: assert property (@(posedge clk) disable iff (rst)
      (wait_r != 4'h0) |-> channel_drive == CH_ALL_OFF)
      else $error("Channel driven during transition wait.");
   drive_mode_a: assert property (@(posedge clk) disable iff (rst)
      channel_drive != CH_ALL_OFF |-> mode_r inside {MODE_ACTIVE, MODE_LIMP})
      else $error("Drive outside driving mode.");
   deep_uv_a: assert property (@(posedge clk) disable iff (rst)
      (lk2_r[0] && lk2_r[2]) |=> channel_drive == CH_ALL_OFF)
      else $error("Channel driven in deep undervoltage.");
   sleep_drop_a: assert property (@(posedge clk) disable iff (rst)
      (!sl2_r && !limp_ok) |=> mode_r == MODE_SLEEP)
      else $error("Limp-home kept in deep undervoltage.");
endmodule // operation_mode_supply_control
`default_nettype wire

/* File: logic/opmode_pkg.sv */
// Shared constants and types for the operation-mode controller.
package opmode_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_IN = 2;
   // Default channel of each direct input pin (input 0 -> ch 2, 1 -> ch 3).
   localparam logic [3:0] IN0_DEFAULT_CH = 4'h4;
   localparam logic [3:0] IN1_DEFAULT_CH = 4'h8;
   localparam logic [3:0] CH_ALL_OFF = 4'h0;
   // Mode transition latency added to turn-on outside active or limp-home.
   localparam int TRANSITION_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TRANSITION_CYCLES =
      (TRANSITION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TRANSITION_CNT = 4'(TRANSITION_CYCLES);
   // Battery supply floor below which limp-home is unavailable under logic undervoltage, in mV.
   localparam int VS_FLOOR_MV = 3000;
   // Serial clock ceilings offered to the host, in kHz.
   localparam int SCLK_LOW_KHZ = 1000;
   localparam int SCLK_FULL_KHZ = 5000;
   typedef enum logic [1:0]
   {
      MODE_SLEEP = 2'b00,
      MODE_IDLE = 2'b01,
      MODE_ACTIVE = 2'b11,
      MODE_LIMP = 2'b10
   } mode_t;
endpackage

/* File: testbench/host_model.sv */
// Host controller model that drives the mode pins and register bits.
`timescale 1ns/10ps
`default_nettype none
module host_model
   import opmode_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req_s,
   input wire logic [1:0] req_i,
   input wire logic [3:0] req_c,
   input wire logic req_h,
   input wire logic serial_slow_only,
   output logic sleep_ctrl_pin,
   output logic [1:0] direct_input_pins,
   output logic [3:0] channel_on_bits,
   output logic hold_active_bit,
   output int sclk_khz
);
   // Pins move only just after a clock edge, as a real host would.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sleep_ctrl_pin <= 1'h0;
         direct_input_pins <= 2'h0;
         channel_on_bits <= 4'h0;
         hold_active_bit <= 1'h0;
      end
      else
      begin
         sleep_ctrl_pin <= req_s;
         direct_input_pins <= req_i;
         channel_on_bits <= req_c;
         hold_active_bit <= req_h;
      end
   end
   // The serial clock must drop on a weak supply.
   assign sclk_khz = serial_slow_only ? SCLK_LOW_KHZ : SCLK_FULL_KHZ;
endmodule // host_model
`default_nettype wire

/* File: testbench/operation_mode_supply_control_tb.sv */
// Self-checking bench for the operation-mode controller.
`timescale 1ns/10ps
`default_nettype none
module operation_mode_supply_control_tb
   import opmode_pkg::*;
   ;
   logic clk, rst, link_clk, rs, rh, sp, hb, ua, la, ba, oa, uv, lo, bl, bo;
   logic [1:0] ri, ip, md;
   logic [3:0] rc, cb, dr;
   logic rr, we, re, st, so;
   int err_count, n_compared, sk;
   host_model u_host_model (.clk(clk), .rst(rst), .req_s(rs), .req_i(ri),
      .req_c(rc), .req_h(rh), .serial_slow_only(so), .sleep_ctrl_pin(sp),
      .direct_input_pins(ip), .channel_on_bits(cb), .hold_active_bit(hb),
      .sclk_khz(sk));
   operation_mode_supply_control u_operation_mode_supply_control (
      .clk(clk), .rst(rst), .link_clk(link_clk), .sleep_ctrl_pin(sp),
      .direct_input_pins(ip), .channel_on_bits(cb), .hold_active_bit(hb),
      .logic_supply_uv(uv), .logic_supply_low_op(lo),
      .battery_supply_low(bl), .battery_above_op(bo), .mode(md),
      .channel_drive(dr), .regs_reset(rr), .serial_write_en(we),
      .serial_read_en(re), .serial_out_tristate(st), .serial_slow_only(so));
   always #5 clk = ~clk;
   // Supply flags come from the link domain so that they cross in earnest.
   always @(posedge link_clk)
   begin
      uv <= ua;
      lo <= la;
      bl <= ba;
      bo <= oa;
   end
   task automatic check(input string w, input logic [7:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", w, e, s);
      end
   endtask
   task automatic go(input logic s, input logic [1:0] i,
      input logic [3:0] c, input logic h, input int n);
      rs <= s;
      ri <= i;
      rc <= c;
      rh <= h;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #20000;
      err_count++;
      stop_test();
   end
   initial
   begin
      {clk, rst, rs, ri, rc, rh, ua, la, ba, oa} = '0;
      link_clk = 1'h0;
      err_count = 0;
      n_compared = 0;
      rst = 1'h1;
      fork
         begin
            #7;
            forever #16 link_clk = ~link_clk;
         end
      join_none
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      go(0, 0, 0, 0, 6);
      check("mode", md, MODE_SLEEP);
      check("regs_reset", rr, 1);
      check("tristate", st, 1);
      go(1, 0, 0, 0, 8);
      check("mode", md, MODE_IDLE);
      check("write_en", we, 1);
      $display("test sleep_idle done");
      go(1, 1, 0, 0, 9);
      check("mode", md, MODE_ACTIVE);
      check("drive", dr, CH_ALL_OFF);
      go(1, 1, 0, 0, 10);
      check("drive", dr, IN0_DEFAULT_CH);
      go(1, 0, 1, 0, 8);
      check("drive", dr, 4'h1);
      go(1, 0, 0, 1, 8);
      check("mode", md, MODE_ACTIVE);
      go(1, 0, 0, 0, 8);
      check("mode", md, MODE_IDLE);
      $display("test active done");
      go(0, 2, 1, 0, 20);
      check("mode", md, MODE_LIMP);
      check("drive", dr, IN1_DEFAULT_CH);
      check("write_en", we, 0);
      check("read_en", re, 1);
      go(0, 0, 0, 0, 8);
      check("mode", md, MODE_SLEEP);
      check("drive", dr, CH_ALL_OFF);
      $display("test limp done");
      ua <= 1'h1;
      go(1, 0, 1, 1, 20);
      check("mode", md, MODE_IDLE);
      check("regs_reset", rr, 1);
      check("write_en", we, 0);
      ba <= 1'h1;
      go(0, 1, 0, 0, 20);
      check("mode", md, MODE_SLEEP);
      check("drive", dr, CH_ALL_OFF);
      ua <= 1'h0;
      ba <= 1'h0;
      la <= 1'h1;
      go(1, 0, 0, 0, 20);
      check("slow_only", so, 1);
      check("sclk_low", sk == SCLK_LOW_KHZ, 1);
      oa <= 1'h1;
      go(1, 0, 0, 0, 20);
      check("slow_only", so, 0);
      check("sclk_full", sk == SCLK_FULL_KHZ, 1);
      $display("test supply done");
      stop_test();
   end
endmodule // operation_mode_supply_control_tb
`default_nettype wire
